//--- hw/wss_wake_source.sv
/*
 * Wake source status logic: APB register slave holding the wake enables,
 * the magic and broadcast received flags, the wake options and the wake
 * source register, with the event qualification in front of it.
 * Assumes frame events come from MAC logic on mclk as one-cycle pulses,
 * while pin wake inputs come straight from pads and are resynchronised.
 */
// Implementation choice: the APB register port.
// Functional notes
// - Magic packet received sets control bit 5; software write-one clears it.
// - Broadcast frame received sets control bit 4; software write-one clears it.
// - Resume completion clears bits 5 and 4 when status auto-clear option set.
// - Resume completion clears the four wake enables when enable auto-clear set.
// - Enable bit 3 allows waking on station address match.
// - Enable bit 2 allows waking on programmed pattern frame filters.
// - Enable bit 1 selects magic packet wake; resets to zero.
// - Enable bit 0 allows waking on broadcast; resets to zero.
// - Wake source register at offset 144h records the waking event.
// - Events during suspend entry are not recorded.
// - Events after waking has begun are ignored.
// - One packet matching several conditions sets every matching bit.
// - Wake source bits stay set until software clears them or, for bits 14 and 13, turns EEE off.
// - Bits 31:20 record which of twelve pins caused the wake.
// - Bit 16 records IPv6 SYN, bit 15 IPv4 SYN wakes.
// - Bit 14 records transmit idle exit; needs enable and EEE on.
// - Bit 13 records receive idle exit; needs enable and EEE on.
// - Bit 12 records a receive filter engine frame wake.
// - Bits 11, 10, 9, 8 record station, magic, broadcast, pattern wakes.
// - Bits 4:0 hold matching filter index, valid while bit 8 set.
// - Thirty-two filters, so five index bits cover all of them.
`timescale 1ns/1ns
module wss_wake_source (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Wake events from the MAC, one-cycle pulses on mclk
    input wire logic magic_pkt_rx,
    input wire logic bcast_rx,
    input wire logic station_addr_rx,
    input wire logic pattern_frame_rx,
    input wire logic [4:0] pattern_filter_index,
    input wire logic rx_filter_frame_rx,
    input wire logic v4_syn_rx,
    input wire logic v6_syn_rx,
    input wire logic tx_lpi_exit,
    input wire logic rx_lpi_exit,
    // Pin wake inputs from pads, asynchronous
    input wire logic [11:0] pin_wake,
    // Power management state
    input wire logic suspend_state,
    input wire logic suspend_entry,
    input wire logic resume_done,
    // Wake request to the power manager
    output logic wake_request
);
    wss_wake_if wk ();

    logic [3:0] wake_en;
    logic magic_pkt_seen;
    logic bcast_frame_seen;
    logic [4:0] cfg;
    logic [11:0] pin_meta;
    logic [11:0] pin_sync;
    logic [11:0] pin_prev;
    logic [31:0] byte_mask;
    logic [31:0] wmask;
    logic access;
    logic wr_ctrl;
    logic wr_source;
    logic wr_cfg;
    logic mapped;
    logic [31:0] ctrl_view;
    logic [31:0] cfg_view;
    logic [31:0] next_rdata;
    logic [31:0] src_events;
    logic station_addr_wake_en;
    logic pattern_frame_wake_en;
    logic magic_wake_en;
    logic bcast_wake_en;
    logic energy_efficient_on;
    logic tx_lpi_exit_wake_en;
    logic rx_lpi_exit_wake_en;

    assign bcast_wake_en = wake_en[wss_pkg::WSS_CTRL_BCAST_WAKE_EN];
    assign magic_wake_en = wake_en[wss_pkg::WSS_CTRL_MAGIC_EN];
    assign pattern_frame_wake_en = wake_en[wss_pkg::WSS_CTRL_PATTERN_EN];
    assign station_addr_wake_en = wake_en[wss_pkg::WSS_CTRL_STATION_EN];
    assign tx_lpi_exit_wake_en = cfg[wss_pkg::WSS_CFG_TX_LPI_EN];
    assign rx_lpi_exit_wake_en = cfg[wss_pkg::WSS_CFG_RX_LPI_EN];
    assign energy_efficient_on = cfg[wss_pkg::WSS_CFG_EEE_ON];

    // ==================================================================
    // Bus decode. The write lands at the access edge, where pready is high.
    assign access = psel && penable && pready;
    assign wr_ctrl = access && pwrite && (paddr == wss_pkg::WSS_ADDR_CTRL);
    assign wr_source = access && pwrite && (paddr == wss_pkg::WSS_ADDR_SOURCE);
    assign wr_cfg = access && pwrite && (paddr == wss_pkg::WSS_ADDR_CFG);
    assign mapped = (paddr == wss_pkg::WSS_ADDR_CTRL) || (paddr == wss_pkg::WSS_ADDR_SOURCE)
        || (paddr == wss_pkg::WSS_ADDR_CFG);

    // Byte strobes expand to a bit mask of the written lanes.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            byte_mask[i*8 +: 8] = {8{pstrb[i]}};
        end
        wmask = pwdata & byte_mask;
    end

    // ==================================================================
    // Read views of the three registers.
    always_comb begin
        ctrl_view = wss_pkg::WSS_ZERO;
        ctrl_view[3:0] = wake_en;
        ctrl_view[wss_pkg::WSS_CTRL_BCAST_SEEN] = bcast_frame_seen;
        ctrl_view[wss_pkg::WSS_CTRL_MAGIC_SEEN] = magic_pkt_seen;
        cfg_view = wss_pkg::WSS_ZERO;
        cfg_view[4:0] = cfg;
        cfg_view[wss_pkg::WSS_CFG_ARMED] = wk.armed;
        cfg_view[wss_pkg::WSS_CFG_WAKING] = wk.waking;
        case (paddr)
            wss_pkg::WSS_ADDR_CTRL: begin
                next_rdata = ctrl_view;
            end
            wss_pkg::WSS_ADDR_SOURCE: begin
                next_rdata = wk.source;
            end
            wss_pkg::WSS_ADDR_CFG: begin
                next_rdata = cfg_view;
            end
            default: begin
                next_rdata = wss_pkg::WSS_ZERO;
            end
        endcase
    end

    // Zero wait states: pready rises in the access cycle after setup.
    // Read data are taken at setup, so a read never disturbs state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= wss_pkg::WSS_ZERO;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // ==================================================================
    // Wake enables. A software write wins over the resume auto-clear.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_en <= wss_pkg::WSS_ENABLES_RESET;
        end else if (wr_ctrl && pstrb[0]) begin
            wake_en <= pwdata[3:0];
        end else if (resume_done && cfg[wss_pkg::WSS_CFG_RES_CLR_EN]) begin
            wake_en <= wss_pkg::WSS_ENABLES_RESET;
        end
    end

    // Received flags. A new frame in the clearing cycle keeps its flag.
    always_ff @(posedge mclk) begin
        if (rst) begin
            magic_pkt_seen <= 1'b0;
            bcast_frame_seen <= 1'b0;
        end else begin
            if (magic_pkt_rx) begin
                magic_pkt_seen <= 1'b1;
            end else if (wr_ctrl && wmask[wss_pkg::WSS_CTRL_MAGIC_SEEN]) begin
                magic_pkt_seen <= 1'b0;
            end else if (resume_done && cfg[wss_pkg::WSS_CFG_RES_CLR_STS]) begin
                magic_pkt_seen <= 1'b0;
            end
            if (bcast_rx) begin
                bcast_frame_seen <= 1'b1;
            end else if (wr_ctrl && wmask[wss_pkg::WSS_CTRL_BCAST_SEEN]) begin
                bcast_frame_seen <= 1'b0;
            end else if (resume_done && cfg[wss_pkg::WSS_CFG_RES_CLR_STS]) begin
                bcast_frame_seen <= 1'b0;
            end
        end
    end

    // Wake options and the energy-efficient enable.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg <= wss_pkg::WSS_CFG_RESET;
        end else if (wr_cfg && pstrb[0]) begin
            cfg <= pwdata[4:0];
        end
    end

    // ==================================================================
    // Pin wake inputs: two flip-flops, then a rising edge detector that
    // only ever looks at the second stage.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_meta <= 12'h000;
            pin_sync <= 12'h000;
            pin_prev <= 12'h000;
        end else begin
            pin_meta <= pin_wake;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // ==================================================================
    // Event qualification. Each enable gates only its own source, so a
    // packet that matches several enabled conditions marks all of them.
    always_comb begin
        src_events = wss_pkg::WSS_ZERO;
        src_events[wss_pkg::WSS_SRC_V6_SYN] = v6_syn_rx;
        src_events[wss_pkg::WSS_SRC_V4_SYN] = v4_syn_rx;
        src_events[wss_pkg::WSS_SRC_TX_LPI] = tx_lpi_exit && tx_lpi_exit_wake_en
            && energy_efficient_on;
        src_events[wss_pkg::WSS_SRC_RX_LPI] = rx_lpi_exit && rx_lpi_exit_wake_en
            && energy_efficient_on;
        src_events[wss_pkg::WSS_SRC_RFE] = rx_filter_frame_rx;
        src_events[wss_pkg::WSS_SRC_STATION] = station_addr_rx && station_addr_wake_en;
        src_events[wss_pkg::WSS_SRC_MAGIC] = magic_pkt_rx && magic_wake_en;
        src_events[wss_pkg::WSS_SRC_BCAST] = bcast_rx && bcast_wake_en;
        src_events[wss_pkg::WSS_SRC_PATTERN] = pattern_frame_rx && pattern_frame_wake_en;
    end

    // Drive the capture engine.
    assign wk.event_bits = src_events;
    assign wk.pin_hit = pin_sync & ~pin_prev;
    // five bits name any of 32 filters
    assign wk.pattern_index = pattern_filter_index;
    assign wk.suspended = suspend_state;
    assign wk.suspend_entry = suspend_entry;
    assign wk.resume_done = resume_done;
    assign wk.eee_on = energy_efficient_on;
    // clears come from software writes only
    assign wk.source_clear = wr_source ? wmask : wss_pkg::WSS_ZERO;

    wss_wake_capture u_capture (
        .mclk(mclk),
        .rst(rst),
        .wk(wk)
    );

    // The request pulse is already a flip-flop inside the capture engine.
    assign wake_request = wk.wake_request;
endmodule // wss_wake_source

//--- hw/wss_pkg.sv
/*
 * Constants for the wake source status block: register offsets, field
 * positions, reset values and the wake capture state encoding.
 * Assumes a 12-bit APB byte address and 32-bit data.
 */
package wss_pkg;
    // ==================================================================
    // Register map
    localparam logic [11:0] WSS_ADDR_CTRL = 12'h140;
    localparam logic [11:0] WSS_ADDR_SOURCE = 12'h144;
    localparam logic [11:0] WSS_ADDR_CFG = 12'h148;
    localparam logic [31:0] WSS_ZERO = 32'h00000000;

    // ==================================================================
    // Wake control register fields
    localparam int WSS_CTRL_BCAST_WAKE_EN = 0;
    localparam int WSS_CTRL_MAGIC_EN = 1;
    localparam int WSS_CTRL_PATTERN_EN = 2;
    localparam int WSS_CTRL_STATION_EN = 3;
    localparam int WSS_CTRL_BCAST_SEEN = 4;
    localparam int WSS_CTRL_MAGIC_SEEN = 5;
    localparam logic [3:0] WSS_ENABLES_RESET = 4'h0;

    // ==================================================================
    // Wake configuration register fields
    localparam int WSS_CFG_RES_CLR_STS = 0;
    localparam int WSS_CFG_RES_CLR_EN = 1;
    localparam int WSS_CFG_TX_LPI_EN = 2;
    localparam int WSS_CFG_RX_LPI_EN = 3;
    localparam int WSS_CFG_EEE_ON = 4;
    localparam int WSS_CFG_ARMED = 8;
    localparam int WSS_CFG_WAKING = 9;
    localparam logic [4:0] WSS_CFG_RESET = 5'h00;

    // ==================================================================
    // Wake source register fields
    localparam int WSS_PIN_COUNT = 12;
    localparam int WSS_SRC_PIN_LSB = 20;
    localparam int WSS_SRC_V6_SYN = 16;
    localparam int WSS_SRC_V4_SYN = 15;
    localparam int WSS_SRC_TX_LPI = 14;
    localparam int WSS_SRC_RX_LPI = 13;
    localparam int WSS_SRC_RFE = 12;
    localparam int WSS_SRC_STATION = 11;
    localparam int WSS_SRC_MAGIC = 10;
    localparam int WSS_SRC_BCAST = 9;
    localparam int WSS_SRC_PATTERN = 8;
    localparam int WSS_IDX_W = 5;
    localparam int WSS_FILTER_COUNT = 32;
    localparam logic [WSS_IDX_W-1:0] WSS_IDX_RESET = 5'h00;
    localparam logic [31:0] WSS_SOURCE_RESET = 32'h00000000;

    // ==================================================================
    // Wake capture states
    typedef enum logic [1:0] {
        WSS_AWAKE = 2'b00,
        WSS_ARMED = 2'b01,
        WSS_WAKING = 2'b10
    } wss_state_type;
endpackage

//--- hw/wss_wake_if.sv
/*
 * Signals between the register core and the wake capture engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface wss_wake_if;
    // Qualified wake events, one cycle each.
    logic [11:0] pin_hit;
    logic [31:0] event_bits;
    logic [4:0] pattern_index;
    // Power state and software clears.
    logic suspended;
    logic suspend_entry;
    logic resume_done;
    logic eee_on;
    logic [31:0] source_clear;
    // Results.
    logic [31:0] source;
    logic armed;
    logic waking;
    logic wake_request;

    modport core (output pin_hit, event_bits, pattern_index, suspended, suspend_entry,
        resume_done, eee_on, source_clear, input source, armed, waking, wake_request);
    modport capture (input pin_hit, event_bits, pattern_index, suspended, suspend_entry,
        resume_done, eee_on, source_clear, output source, armed, waking, wake_request);
endinterface // wss_wake_if

//--- hw/wss_wake_capture.sv
/*
 * Wake capture engine: decides when wake events may be recorded and
 * holds the wake source register.
 * Assumes events arrive already qualified by their enables.
 */
`timescale 1ns/1ns
module wss_wake_capture (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link to the register core
    wss_wake_if.capture wk
);
    wss_pkg::wss_state_type state;
    logic [31:0] hits;
    logic record;

    // Gather every event of this cycle, pins included.
    always_comb begin
        hits = wk.event_bits;
        hits[wss_pkg::WSS_SRC_PIN_LSB +: wss_pkg::WSS_PIN_COUNT] = wk.pin_hit;
    end

    assign record = (state == wss_pkg::WSS_ARMED) && !wk.suspend_entry && (|hits);

    // ==================================================================
    // State of the wake sequence.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= wss_pkg::WSS_AWAKE;
        end else begin
            case (state)
                wss_pkg::WSS_AWAKE: begin
                    if (wk.suspended && !wk.suspend_entry) begin
                        state <= wss_pkg::WSS_ARMED;
                    end
                end
                wss_pkg::WSS_ARMED: begin
                    if (record) begin
                        state <= wss_pkg::WSS_WAKING;
                    end else if (!wk.suspended) begin
                        state <= wss_pkg::WSS_AWAKE;
                    end
                end
                wss_pkg::WSS_WAKING: begin
                    if (wk.resume_done) begin
                        state <= wss_pkg::WSS_AWAKE;
                    end
                end
                default: begin
                    state <= wss_pkg::WSS_AWAKE;
                end
            endcase
        end
    end

    // ==================================================================
    // Wake source bits. A record in the clearing cycle wins over the clear.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wk.source <= wss_pkg::WSS_SOURCE_RESET;
        end else begin
            wk.source <= (wk.source & ~wk.source_clear) | (record ? hits : wss_pkg::WSS_ZERO);
            if (record && hits[wss_pkg::WSS_SRC_PATTERN]) begin
                wk.source[wss_pkg::WSS_IDX_W-1:0] <= wk.pattern_index;
            end else if (|wk.source_clear[wss_pkg::WSS_IDX_W-1:0]) begin
                wk.source[wss_pkg::WSS_IDX_W-1:0] <= wss_pkg::WSS_IDX_RESET;
            end
            if (!wk.eee_on) begin
                wk.source[wss_pkg::WSS_SRC_TX_LPI] <= 1'b0;
                wk.source[wss_pkg::WSS_SRC_RX_LPI] <= 1'b0;
            end
        end
    end

    // Status and wake request pulse.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wk.wake_request <= 1'b0;
            wk.armed <= 1'b0;
            wk.waking <= 1'b0;
        end else begin
            wk.wake_request <= record;
            wk.armed <= (state == wss_pkg::WSS_ARMED) && !record;
            wk.waking <= record || ((state == wss_pkg::WSS_WAKING) && !wk.resume_done);
        end
    end
endmodule // wss_wake_capture

//--- verification/wss_wake_source_assertions.sv
/*
 * Port-level concurrent checks for the wake source status block.
 * Assumes a single clock mclk and a synchronous active-high reset rst.
 */
`timescale 1ns/1ns
module wss_wake_source_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Power state and wake output
    input wire logic suspend_entry,
    input wire logic resume_done,
    input wire logic wake_request
);
    // ==================================================================
    // Shared timing and sequences
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic mapped;

    // Decode of the three mapped registers, held with the request.
    assign mapped = (paddr == wss_pkg::WSS_ADDR_CTRL) || (paddr == wss_pkg::WSS_ADDR_SOURCE)
        || (paddr == wss_pkg::WSS_ADDR_CFG);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    sequence s_waking_quiet;
        !resume_done [*4];
    endsequence

    // ==================================================================
    // Bus answers
    AST_READY_AFTER_SETUP: assert property (s_setup |=> s_answer)
        else $error("pready did not follow the setup cycle for exactly one cycle");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
        else $error("pready raised without a setup cycle before it");
    AST_MAPPED_OK: assert property (psel && !penable && mapped |=> !pslverr)
        else $error("error response on a mapped register");
    AST_UNMAPPED_ERR: assert property (psel && !penable && !mapped |=>
        pslverr && (pwrite || prdata == wss_pkg::WSS_ZERO))
        else $error("unmapped access not refused with zero data");
    AST_SOURCE_RESERVED: assert property (psel && penable && pready && !pwrite &&
        paddr == wss_pkg::WSS_ADDR_SOURCE |-> prdata[19:17] == 3'h0 && prdata[7:5] == 3'h0)
        else $error("reserved wake source bits read nonzero");

    // ==================================================================
    // Wake recording
    AST_REQ_PULSE: assert property (wake_request |=> !wake_request)
        else $error("wake request longer than one cycle");
    AST_NO_ENTRY_RECORD: assert property (suspend_entry |=> !wake_request)
        else $error("wake recorded while suspend was being entered");
    AST_HOLD_UNTIL_RESUME: assert property (wake_request ##1 s_waking_quiet |=>
        !wake_request)
        else $error("second wake recorded before resume completed");
    AST_RESET_QUIET: assert property (disable iff (1'b0) rst |=>
        !pready && !pslverr && !wake_request && prdata == wss_pkg::WSS_ZERO)
        else $error("outputs not cleared by reset");
endmodule // wss_wake_source_assertions

bind wss_wake_source wss_wake_source_assertions u_chk (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .suspend_entry(suspend_entry), .resume_done(resume_done),
    .wake_request(wake_request));

//--- verification/wss_wake_source_tb_top.sv
/*
 * Self-checking bench for the wake source status block over APB.
 * Assumes the checker is bound in separately; reads are scored from a queue.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module wss_wake_source_tb_top;
    // ==================================================================
    // Signals
    logic mclk, rst, psel, penable, pwrite, sus, entry, resume;
    logic [11:0] paddr, pins;
    logic [31:0] pwdata, prdata, want, src;
    logic [3:0] pstrb, en;
    logic [8:0] ev;
    logic [4:0] pat_idx, idx;
    logic pready, pslverr, wake_request;
    logic [31:0] exp_q[$];
    int n_fail, compares, n_wake, p, k;

    wss_wake_source uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .magic_pkt_rx(ev[8]), .bcast_rx(ev[7]),
        .station_addr_rx(ev[6]), .pattern_frame_rx(ev[5]), .pattern_filter_index(pat_idx),
        .rx_filter_frame_rx(ev[4]), .v4_syn_rx(ev[3]), .v6_syn_rx(ev[2]),
        .tx_lpi_exit(ev[1]), .rx_lpi_exit(ev[0]), .pin_wake(pins), .suspend_state(sus),
        .suspend_entry(entry), .resume_done(resume), .wake_request(wake_request));

    // Free-running 50 ns clock.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Read results are scored against the oldest expectation.
    always @(posedge mclk) begin
        if (wake_request === 1'b1) n_wake++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            want = exp_q.pop_front();
            `CHK(prdata, want)
            // Only the one unmapped offset used below may answer with an error.
            `CHK(pslverr, paddr == 12'h14C)
        end
    end

    // ==================================================================
    // Tasks
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A wait of twenty cycles is far past the zero-wait answer, so it means a hang.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        // The request stands until the rising edge at which pready is seen high.
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h00000000);
    endtask

    task automatic fire(input logic [8:0] m, input logic [4:0] i);
        @(posedge mclk);
        ev <= m;
        pat_idx <= i;
        @(posedge mclk);
        ev <= 9'h000;
    endtask

    task automatic arm();
        @(posedge mclk);
        sus <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    // Leaving suspend in the same cycle as resume keeps the block from re-arming at resume.
    task automatic wake_done();
        @(posedge mclk);
        sus <= 1'b0;
        resume <= 1'b1;
        @(posedge mclk);
        resume <= 1'b0;
    endtask

    // Hang guard.
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        conclude();
    end

    // ==================================================================
    // Main sequence
    initial begin
        {rst, psel, penable, pwrite, sus, entry, resume} = 7'h01 << 6;
        {paddr, pins, pwdata, ev, pat_idx} = '0;
        pstrb = 4'hF;
        void'($urandom(32'h8A39CCF0));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(wss_pkg::WSS_ADDR_CTRL, 32'h00000000);
        rd(wss_pkg::WSS_ADDR_SOURCE, 32'h00000000);
        rd(wss_pkg::WSS_ADDR_CFG, 32'h00000000);
        rd(12'h14C, 32'h00000000);
        en = 4'($urandom());
        apb(1'b1, wss_pkg::WSS_ADDR_CTRL, {28'h0, en});
        rd(wss_pkg::WSS_ADDR_CTRL, {28'h0, en});
        apb(1'b1, wss_pkg::WSS_ADDR_CTRL, 32'h0000000F);
        fire(9'h180, 5'h00);
        rd(wss_pkg::WSS_ADDR_CTRL, 32'h0000003F);
        apb(1'b1, wss_pkg::WSS_ADDR_CTRL, 32'h0000002F);
        rd(wss_pkg::WSS_ADDR_CTRL, 32'h0000001F);
        apb(1'b1, wss_pkg::WSS_ADDR_CTRL, 32'h0000001F);
        rd(wss_pkg::WSS_ADDR_CTRL, 32'h0000000F);
        apb(1'b1, wss_pkg::WSS_ADDR_CFG, 32'h0000001F);
        arm();
        rd(wss_pkg::WSS_ADDR_CFG, 32'h0000011F);
        idx = 5'($urandom_range(31, 0));
        src = 32'h0001FF00 | {27'h0, idx};
        fire(9'h1FF, idx);
        repeat (2) @(posedge mclk);
        `CHK(n_wake, 1)
        rd(wss_pkg::WSS_ADDR_SOURCE, src);
        fire(9'h004, 5'h00);
        rd(wss_pkg::WSS_ADDR_SOURCE, src);
        rd(wss_pkg::WSS_ADDR_CFG, 32'h0000021F);
        rd(wss_pkg::WSS_ADDR_CTRL, 32'h0000003F);
        wake_done();
        rd(wss_pkg::WSS_ADDR_CTRL, 32'h00000000);
        rd(wss_pkg::WSS_ADDR_SOURCE, src);
        apb(1'b1, wss_pkg::WSS_ADDR_SOURCE, 32'h00000100);
        rd(wss_pkg::WSS_ADDR_SOURCE, src & ~32'h00000100);
        // Turning energy-efficient mode off must drop the two idle-exit bits.
        apb(1'b1, wss_pkg::WSS_ADDR_CFG, 32'h0000000F);
        rd(wss_pkg::WSS_ADDR_SOURCE, src & ~32'h00006100);
        apb(1'b1, wss_pkg::WSS_ADDR_SOURCE, 32'hFFFFFFFF);
        rd(wss_pkg::WSS_ADDR_SOURCE, 32'h00000000);
        arm();
        @(posedge mclk);
        entry <= 1'b1;
        fire(9'h008, 5'h00);
        @(posedge mclk);
        entry <= 1'b0;
        rd(wss_pkg::WSS_ADDR_SOURCE, 32'h00000000);
        p = $urandom_range(11, 0);
        @(posedge mclk);
        pins[p] <= 1'b1;
        k = 0;
        while (n_wake < 2 && k < 20) begin
            @(posedge mclk);
            k++;
        end
        if (n_wake < 2) begin
            n_fail++;
            conclude();
        end
        rd(wss_pkg::WSS_ADDR_SOURCE, 32'h00000001 << (20 + p));
        wake_done();
        pins <= 12'h000;
        apb(1'b1, wss_pkg::WSS_ADDR_SOURCE, 32'hFFFFFFFF);
        apb(1'b1, wss_pkg::WSS_ADDR_CFG, 32'h0000000F);
        arm();
        fire(9'h1F3, 5'h00);
        repeat (2) @(posedge mclk);
        rd(wss_pkg::WSS_ADDR_SOURCE, 32'h00001000);
        `CHK(n_wake, 3)
        wake_done();
        conclude();
    end
endmodule // wss_wake_source_tb_top
